// [hw/gcr_bank.sv]
// general configuration register bank with waveform memory, flag muxing and breakpoint
// Operation
// R1 - 128-byte read/write waveform descriptor memory, contents undefined after power-up
// R2 - with strobe enable set, port C reads and writes pulse read or write strobes
// R3 - clock speed code 00=12, 01=24, 10=48 MHz; 11 undefined
// R4 - invert bit inverts clock output; drive bit enables it onto pin
// R5 - hold-in-reset bit keeps processor reset; read-only from processor side
// R6 - clock source bit picks external pin at 0, internal clock at 1
// R7 - internal interface clock frequency bit picks 30 MHz at 0, 48 at 1
// R8 - interface clock pin driven only when enabled, with polarity bit applied
// R9 - fifo_mode_a bit runs FIFOs and waveform engine from internal clock when 1
// R10 - waveform state output bit drives state bits onto port E bits 0-2
// R11 - mode field: 00 ports, 01 reserved, 10 waveform master, 11 slave FIFO
// R12 - four 4-bit flag selectors; A,B one register, C,D the next, low first
// R13 - code 0000 outputs selected FIFO's level flag; 0001-0011 reserved
// R14 - codes 01xx level, 10xx empty, 11xx full flags of endpoints 2,4,6,8
// R15 - writing a FIFO number to restore register resets its flags and counts
// R16 - restore sequence: write 0x80 NAK all, FIFO number, then 0x00
// R17 - break flag set on fetch match when enabled; pulse or latched indication
// R18 - fixed bit positions ignore writes and read back their fixed values
//
// Added by the designer: the address-and-strobe port.
module gcr_bank (
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    input  wire logic [15:0]         bus_addr,
    input  wire logic [7:0]          bus_wdata,
    input  wire logic                bus_wr,
    input  wire logic                bus_rd,
    output logic [7:0]               bus_rdata,
    input  wire logic                cpu_reset_req,
    input  wire logic                cpu_fetch,
    input  wire logic [15:0]         cpu_fetch_addr,
    input  wire logic                cpu_clk_in,
    input  wire logic                int_clk_30,
    input  wire logic                int_clk_48,
    input  wire logic                iface_clock_pin_in,
    input  wire logic [2:0]          waveform_state,
    input  wire logic [1:0]          fifo_select_pins,
    input  wire gcr_pkg::gcr_flags_t fifo_flags,
    output logic [1:0]               cpu_clock_speed,
    output logic                     cpu_clock_output,
    output logic                     cpu_clock_output_oe,
    output logic                     cpu_hold_in_reset,
    output logic                     port_c_rd_strobe_n,
    output logic                     port_c_wr_strobe_n,
    output logic                     iface_clock_sel,
    output logic                     iface_clock_pin_out,
    output logic                     iface_clock_pin_oe,
    output logic [1:0]               iface_mode_select,
    output logic [2:0]               port_e_c_out,
    output logic [2:0]               port_e_c_oe,
    output logic [3:0]               flag_pins,
    output logic                     nak_all_transfers,
    output logic [3:0]               fifo_restore_strobe,
    output logic                     break_flag,
    output logic                     irq
);
    logic [7:0] wave_mem [0:gcr_pkg::WAVE_DEPTH-1];
    gcr_pkg::gcr_cpu_t   cpu_reg;
    gcr_pkg::gcr_ifcfg_t ifc_reg;
    logic [7:0]  flag_ab_reg, flag_cd_reg, brk_ctl_reg, bp_h_reg, bp_l_reg;
    logic [7:0]  rdata_reg, stat_reg, mask_reg;
    logic        nak_reg, rst_meta_reg, rst_sync_reg, pin_meta_reg, pin_sync_reg;
    logic [1:0]  fsel_meta_reg, fsel_sync_reg;
    logic        strb_rd_reg, strb_wr_reg, brk_reg, clk_out_reg, clk_oe_reg;
    logic        if_sel_reg, if_out_reg, if_oe_reg;
    logic [2:0]  pe_out_reg, pe_oe_reg;
    logic [3:0]  flag_reg, restore_reg;
    logic        irq_reg;
    logic [7:0]  stat_next;

    wire in_wave   = bus_addr[15:7] == gcr_pkg::WAVE_BASE[15:7];
    wire wr_cpu    = bus_wr && bus_addr == gcr_pkg::CPU_CS_OFS;
    wire wr_ifc    = bus_wr && bus_addr == gcr_pkg::IF_CFG_OFS;
    wire wr_fab    = bus_wr && bus_addr == gcr_pkg::FLAG_AB_OFS;
    wire wr_fcd    = bus_wr && bus_addr == gcr_pkg::FLAG_CD_OFS;
    wire wr_rst    = bus_wr && bus_addr == gcr_pkg::FIFO_RST_OFS;
    wire wr_brk    = bus_wr && bus_addr == gcr_pkg::BRK_CTL_OFS;
    wire wr_bph    = bus_wr && bus_addr == gcr_pkg::BRK_ADR_H_OFS;
    wire wr_bpl    = bus_wr && bus_addr == gcr_pkg::BRK_ADR_L_OFS;
    wire wr_stat   = bus_wr && bus_addr == gcr_pkg::IRQ_STAT_OFS;
    wire wr_mask   = bus_wr && bus_addr == gcr_pkg::IRQ_MASK_OFS;
    wire port_c_hit = bus_addr == gcr_pkg::PORT_C_OFS;

    // flag selector decode, used for all four pins
    function automatic logic flag_pick(input logic [3:0] code, input gcr_pkg::gcr_flags_t f,
                                       input logic [1:0] fsel);
        case (code[3:2])
            2'h0:    flag_pick = (code[1:0] == 2'h0) ? f.pl[fsel] : 1'b0; // [R13]
            2'h1:    flag_pick = f.pl[code[1:0]];                          // [R14]
            2'h2:    flag_pick = f.empty[code[1:0]];                       // [R14]
            default: flag_pick = f.full[code[1:0]];                        // [R14]
        endcase
    endfunction

    wire [15:0] flag_codes = {flag_cd_reg, flag_ab_reg}; // [R12]
    logic [3:0] flag_next;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            assign flag_next[gi] = flag_pick(flag_codes[gi*4 +: 4], fifo_flags, fsel_sync_reg);
        end
    endgenerate

    // restore names a FIFO on any nonzero low nibble, whether NAK is up or not; plain 0x00/0x80 are control words
    wire [3:0] restore_next = (wr_rst && bus_wdata[3:0] != 4'h0) ? bus_wdata[3:0] : 4'h0; // [R15]
    wire       bp_hit   = brk_ctl_reg[gcr_pkg::BRK_EN_BIT] && cpu_fetch
                          && cpu_fetch_addr == {bp_h_reg, bp_l_reg};                     // [R17]
    wire       brk_next = bp_hit | (brk_reg & ~brk_ctl_reg[gcr_pkg::BRK_PULSE_BIT]
                          & ~(wr_brk & bus_wdata[gcr_pkg::BRK_FLAG_BIT]));               // [R17]
    wire [7:0] evt = {6'h00, |restore_next, bp_hit};
    // a fifo-number write keeps nak up until the closing 0x00
    wire       nak_load = wr_rst && (bus_wdata[gcr_pkg::NAK_BIT] || bus_wdata[3:0] == 4'h0); // [R16]
    // set wins over write-one-to-clear
    assign stat_next = (stat_reg & ~(wr_stat ? bus_wdata : 8'h00)) | evt;

    wire       sel_int    = ifc_reg.iface_clock_source | ifc_reg.fifo_mode_a;       // [R6] [R9]
    wire       int_clk    = ifc_reg.iface_clock_freq_select ? int_clk_48 : int_clk_30; // [R7]
    wire       if_clk_mux = sel_int ? int_clk : pin_sync_reg;                        // [R6]
    wire [7:0] brk_rd = {4'h0, brk_reg, brk_ctl_reg[2:1], 1'b0};                     // [R18]
    wire [7:0] cpu_rd = {2'h0, cpu_reg};                                             // [R18]
    logic [7:0] rd_mux;
    assign rd_mux = in_wave                                ? wave_mem[bus_addr[6:0]] :
                    bus_addr == gcr_pkg::CPU_CS_OFS        ? cpu_rd :
                    bus_addr == gcr_pkg::IF_CFG_OFS        ? ifc_reg :
                    bus_addr == gcr_pkg::FLAG_AB_OFS       ? flag_ab_reg :
                    bus_addr == gcr_pkg::FLAG_CD_OFS       ? flag_cd_reg :
                    bus_addr == gcr_pkg::BRK_CTL_OFS       ? brk_rd :
                    bus_addr == gcr_pkg::BRK_ADR_H_OFS     ? bp_h_reg :
                    bus_addr == gcr_pkg::BRK_ADR_L_OFS     ? bp_l_reg :
                    bus_addr == gcr_pkg::IRQ_STAT_OFS      ? stat_reg :
                    bus_addr == gcr_pkg::IRQ_MASK_OFS      ? mask_reg : 8'h00;

    always_ff @(posedge core_clk) begin
        if (bus_wr && in_wave) begin
            wave_mem[bus_addr[6:0]] <= bus_wdata; // [R1]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg  <= 1'b0;
            rst_sync_reg  <= 1'b0;
            pin_meta_reg  <= 1'b0;
            pin_sync_reg  <= 1'b0;
            fsel_meta_reg <= 2'h0;
            fsel_sync_reg <= 2'h0;
        end else begin
            rst_meta_reg  <= cpu_reset_req;
            rst_sync_reg  <= rst_meta_reg;
            pin_meta_reg  <= iface_clock_pin_in;
            pin_sync_reg  <= pin_meta_reg;
            fsel_meta_reg <= fifo_select_pins;
            fsel_sync_reg <= fsel_meta_reg;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_reg     <= gcr_pkg::CPU_CS_RST[5:0];
            ifc_reg     <= gcr_pkg::IF_CFG_RST;
            flag_ab_reg <= gcr_pkg::FLAG_AB_RST;
            flag_cd_reg <= gcr_pkg::FLAG_CD_RST;
            brk_ctl_reg <= gcr_pkg::BRK_CTL_RST;
            bp_h_reg    <= 8'h00;
            bp_l_reg    <= 8'h00;
            nak_reg     <= 1'b0;
        end else begin
            if (wr_cpu) begin
                // hold-in-reset bit comes from the reset controller, not software
                cpu_reg[5:1] <= bus_wdata[5:1];   // [R2] [R18]
            end
            cpu_reg.cpu_hold_in_reset <= rst_sync_reg; // [R5]
            if (wr_ifc) ifc_reg <= bus_wdata;
            if (wr_fab) flag_ab_reg <= bus_wdata; // [R12]
            if (wr_fcd) flag_cd_reg <= bus_wdata; // [R12]
            if (wr_brk) brk_ctl_reg <= bus_wdata & gcr_pkg::BRK_CTL_WMASK; // [R18]
            if (wr_bph) bp_h_reg <= bus_wdata;
            if (wr_bpl) bp_l_reg <= bus_wdata;
            if (nak_load) nak_reg <= bus_wdata[gcr_pkg::NAK_BIT]; // [R16]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg   <= 8'h00;
            stat_reg    <= 8'h00;
            mask_reg    <= 8'h00;
            strb_rd_reg <= 1'b1;
            strb_wr_reg <= 1'b1;
            brk_reg     <= 1'b0;
            restore_reg <= 4'h0;
            flag_reg    <= 4'h0;
            irq_reg     <= 1'b0;
        end else begin
            rdata_reg   <= bus_rd ? rd_mux : 8'h00;
            stat_reg    <= stat_next;
            if (wr_mask) mask_reg <= bus_wdata;
            strb_rd_reg <= ~(cpu_reg.port_c_strobe_enable & bus_rd & port_c_hit); // [R2]
            strb_wr_reg <= ~(cpu_reg.port_c_strobe_enable & bus_wr & port_c_hit); // [R2]
            brk_reg     <= brk_next;
            restore_reg <= restore_next; // [R15]
            flag_reg    <= flag_next;
            irq_reg     <= |(stat_reg & mask_reg);
        end
    end

    // pin-facing registers; clock pins are resampled so outputs stay flop-driven
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_out_reg <= 1'b0;
            clk_oe_reg  <= 1'b0;
            if_sel_reg  <= 1'b0;
            if_out_reg  <= 1'b0;
            if_oe_reg   <= 1'b0;
            pe_out_reg  <= 3'h0;
            pe_oe_reg   <= 3'h0;
        end else begin
            clk_out_reg <= cpu_clk_in ^ cpu_reg.clock_out_invert;           // [R4]
            clk_oe_reg  <= cpu_reg.clock_out_drive;                         // [R4]
            if_sel_reg  <= sel_int;                                         // [R6] [R9]
            if_out_reg  <= if_clk_mux ^ ifc_reg.iface_clock_polarity;       // [R8]
            if_oe_reg   <= ifc_reg.iface_clock_out_drive;                   // [R8]
            pe_out_reg  <= waveform_state;                                  // [R10]
            pe_oe_reg   <= {3{ifc_reg.waveform_state_out}};                 // [R10]
        end
    end

    assign bus_rdata           = rdata_reg;
    assign cpu_clock_speed     = cpu_reg.cpu_clock_speed; // [R3]
    assign cpu_clock_output    = clk_out_reg;
    assign cpu_clock_output_oe = clk_oe_reg;
    assign cpu_hold_in_reset   = cpu_reg.cpu_hold_in_reset;
    assign port_c_rd_strobe_n  = strb_rd_reg;
    assign port_c_wr_strobe_n  = strb_wr_reg;
    assign iface_clock_sel     = if_sel_reg;
    assign iface_clock_pin_out = if_out_reg;
    assign iface_clock_pin_oe  = if_oe_reg;
    assign iface_mode_select   = ifc_reg.iface_mode_select; // [R11]
    assign port_e_c_out        = pe_out_reg;
    assign port_e_c_oe         = pe_oe_reg;
    assign flag_pins           = flag_reg;
    assign nak_all_transfers   = nak_reg;
    assign fifo_restore_strobe = restore_reg;
    assign break_flag          = brk_reg;
    assign irq                 = irq_reg;

    a_port_c_strobe: assert property (@(posedge core_clk) disable iff (!arst_n) // [R2]
        cpu_reg.port_c_strobe_enable && bus_wr && port_c_hit |=> !port_c_wr_strobe_n)
        else $error("port c write strobe missing");
    a_rd_strobe_off: assert property (@(posedge core_clk) disable iff (!arst_n) // [R2]
        !cpu_reg.port_c_strobe_enable |=> port_c_rd_strobe_n)
        else $error("read strobe while disabled");
    a_cpu_reset_follow: assert property (@(posedge core_clk) disable iff (!arst_n) // [R5]
        $rose(rst_sync_reg) |=> cpu_hold_in_reset)
        else $error("hold in reset not followed");
    a_cpu_fixed_bits: assert property (@(posedge core_clk) disable iff (!arst_n) // [R18]
        bus_rd && bus_addr == gcr_pkg::CPU_CS_OFS |=> bus_rdata[7:6] == 2'h0)
        else $error("fixed bits not zero");
    a_iface_oe: assert property (@(posedge core_clk) disable iff (!arst_n) // [R8]
        ##1 iface_clock_pin_oe == $past(ifc_reg.iface_clock_out_drive))
        else $error("iface clock drive mismatch");
    a_waveform_state_out_drive: assert property (@(posedge core_clk) disable iff (!arst_n) // [R10]
        ifc_reg.waveform_state_out ##1 ifc_reg.waveform_state_out |-> port_e_c_oe == 3'h7)
        else $error("port e not driven");
    a_flag_full_map: assert property (@(posedge core_clk) disable iff (!arst_n) // [R14]
        flag_ab_reg[3:0] == 4'hC |=> flag_pins[0] == $past(fifo_flags.full[0]))
        else $error("flag a full mapping wrong");
    a_restore_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // [R15]
        wr_rst && bus_wdata == 8'h02 |=> fifo_restore_strobe == 4'h2 ##1 fifo_restore_strobe == 4'h0)
        else $error("restore strobe wrong");
    a_nak_cmd: assert property (@(posedge core_clk) disable iff (!arst_n) // [R16]
        wr_rst && bus_wdata == gcr_pkg::NAK_CMD |=> nak_all_transfers)
        else $error("nak not raised");
    a_break_set: assert property (@(posedge core_clk) disable iff (!arst_n) // [R17]
        bp_hit |=> break_flag ##1 (break_flag || $past(brk_ctl_reg[gcr_pkg::BRK_PULSE_BIT])))
        else $error("break flag not set");
    c_wave_write: cover property (@(posedge core_clk) bus_wr && in_wave);
    c_restore_seq: cover property (@(posedge core_clk) wr_rst && bus_wdata == gcr_pkg::NAK_CMD);
    c_break_hit: cover property (@(posedge core_clk) bp_hit);
    c_irq_up: cover property (@(posedge core_clk) $rose(irq));
endmodule

// [hw/gcr_pkg.sv]
// package: offsets, fields, reset values and types of the general configuration bank
package gcr_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          WAVE_DEPTH      = 128;
    localparam logic [15:0] WAVE_BASE       = 16'hE400;
    localparam logic [15:0] CPU_CS_OFS      = 16'hE600;
    localparam logic [15:0] IF_CFG_OFS      = 16'hE601;
    localparam logic [15:0] FLAG_AB_OFS     = 16'hE602;
    localparam logic [15:0] FLAG_CD_OFS     = 16'hE603;
    localparam logic [15:0] FIFO_RST_OFS    = 16'hE604;
    localparam logic [15:0] BRK_CTL_OFS     = 16'hE605;
    localparam logic [15:0] BRK_ADR_H_OFS   = 16'hE606;
    localparam logic [15:0] BRK_ADR_L_OFS   = 16'hE607;
    localparam logic [15:0] PORT_C_OFS      = 16'h00A0;
    localparam logic [15:0] IRQ_STAT_OFS    = 16'hE6F0;
    localparam logic [15:0] IRQ_MASK_OFS    = 16'hE6F1;
    localparam logic [7:0]  CPU_CS_RST      = 8'h02;
    localparam logic [7:0]  IF_CFG_RST      = 8'hC0;
    localparam logic [7:0]  FLAG_AB_RST     = 8'h00;
    localparam logic [7:0]  FLAG_CD_RST     = 8'h40;
    localparam logic [7:0]  BRK_CTL_RST     = 8'h00;
    localparam logic [7:0]  CPU_CS_WMASK    = 8'h3E;
    localparam logic [7:0]  BRK_CTL_WMASK   = 8'h06;
    localparam logic [7:0]  NAK_CMD         = 8'h80;
    localparam logic [7:0]  NAK_CLR         = 8'h00;
    localparam int          NAK_BIT         = 7;
    localparam int          BRK_FLAG_BIT    = 3;
    localparam int          BRK_PULSE_BIT   = 2;
    localparam int          BRK_EN_BIT      = 1;
    localparam int          IRQ_BREAK_BIT   = 0;
    localparam int          IRQ_RESTORE_BIT = 1;
    localparam int          IRQ_W           = 2;

    typedef struct packed {
        logic       port_c_strobe_enable;
        logic [1:0] cpu_clock_speed;
        logic       clock_out_invert;
        logic       clock_out_drive;
        logic       cpu_hold_in_reset;
    } gcr_cpu_t;

    typedef struct packed {
        logic       iface_clock_source;
        logic       iface_clock_freq_select;
        logic       iface_clock_out_drive;
        logic       iface_clock_polarity;
        logic       fifo_mode_a;
        logic       waveform_state_out;
        logic [1:0] iface_mode_select;
    } gcr_ifcfg_t;

    typedef struct packed {
        logic [3:0] pl;
        logic [3:0] empty;
        logic [3:0] full;
    } gcr_flags_t;
endpackage

// [verification/gcr_fw_model.sv]
// firmware-side model: register port cycles and the fifo restore sequence
module gcr_fw_model (
    input  wire logic        core_clk,
    input  wire logic [7:0]  bus_rdata,
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_wdata,
    output logic             bus_wr,
    output logic             bus_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bus_addr  = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
    end
    // idle cycle after each strobe so a back-to-back call never drives one strobe twice in a step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge core_clk);
        bus_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge core_clk);
        bus_rd   <= 1'b0;
        #1;
        d = bus_rdata;
    endtask
    // nak first so no transfer sees a half-restored fifo
    task automatic restore(input logic [3:0] fifo);
        wr(gcr_pkg::FIFO_RST_OFS, gcr_pkg::NAK_CMD);
        wr(gcr_pkg::FIFO_RST_OFS, {4'h0, fifo});
        wr(gcr_pkg::FIFO_RST_OFS, gcr_pkg::NAK_CLR);
    endtask
endmodule

// [verification/general_config_register_bank_test.sv]
// self-checking bench for the general configuration register bank
module general_config_register_bank_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                core_clk, arst_n, bus_wr, bus_rd, cpu_reset_req, cpu_fetch;
    logic [15:0]         bus_addr, cpu_fetch_addr, a;
    logic [7:0]          bus_wdata, bus_rdata, d, v;
    logic                cpu_clk_in, int_clk_30, int_clk_48, iface_clock_pin_in;
    logic [2:0]          waveform_state, port_e_c_out, port_e_c_oe;
    logic [1:0]          fifo_select_pins, cpu_clock_speed, iface_mode_select;
    gcr_pkg::gcr_flags_t fifo_flags;
    logic                cpu_clock_output, cpu_clock_output_oe, cpu_hold_in_reset, iface_clock_sel;
    logic                port_c_rd_strobe_n, port_c_wr_strobe_n, iface_clock_pin_out, iface_clock_pin_oe;
    logic                nak_all_transfers, break_flag, irq, nak_seen;
    logic [3:0]          flag_pins, fifo_restore_strobe, rst_seen, c, ex;
    int                  fail_count, check_count, wr_pulses, rd_pulses, brk_cycles, seed;
    int                  mem_model [int];
    logic [15:0]         rst_adr [9] = '{16'hE600, 16'hE601, 16'hE602, 16'hE603, 16'hE604, 16'hE605,
                                         16'hE606, 16'hE607, 16'hE480};
    logic [7:0]          rst_val [9] = '{8'h02, 8'hC0, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    gcr_bank DUT (.core_clk, .arst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .cpu_reset_req,
        .cpu_fetch, .cpu_fetch_addr, .cpu_clk_in, .int_clk_30, .int_clk_48, .iface_clock_pin_in,
        .waveform_state, .fifo_select_pins, .fifo_flags, .cpu_clock_speed, .cpu_clock_output,
        .cpu_clock_output_oe, .cpu_hold_in_reset, .port_c_rd_strobe_n, .port_c_wr_strobe_n, .iface_clock_sel,
        .iface_clock_pin_out, .iface_clock_pin_oe, .iface_mode_select, .port_e_c_out, .port_e_c_oe,
        .flag_pins, .nak_all_transfers, .fifo_restore_strobe, .break_flag, .irq);
    gcr_fw_model fw (.core_clk, .bus_rdata, .bus_addr, .bus_wdata, .bus_wr, .bus_rd);

    // pulse counters catch a strobe that lasts two cycles
    always @(posedge core_clk) begin
        if (port_c_wr_strobe_n === 1'b0) wr_pulses++;
        if (port_c_rd_strobe_n === 1'b0) rd_pulses++;
        if (break_flag === 1'b1) brk_cycles++;
        if (fifo_restore_strobe !== 4'h0) begin
            rst_seen = fifo_restore_strobe;
            nak_seen = nak_all_transfers;
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic fetch(input logic [15:0] fa);
        @(posedge core_clk);
        cpu_fetch      <= 1'b1;
        cpu_fetch_addr <= fa;
        @(posedge core_clk);
        cpu_fetch      <= 1'b0;
        idle(3);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic flag_exp(input logic [3:0] k, input logic [1:0] s, input gcr_pkg::gcr_flags_t f);
        case (k[3:2])
            2'b00: flag_exp = (k == 4'h0) ? f.pl[s] : 1'b0;
            2'b01: flag_exp = f.pl[k[1:0]];
            2'b10: flag_exp = f.empty[k[1:0]];
            default: flag_exp = f.full[k[1:0]];
        endcase
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end
    initial begin
        {arst_n, cpu_reset_req, cpu_fetch, cpu_clk_in, int_clk_30, int_clk_48, iface_clock_pin_in} = 7'h00;
        {cpu_fetch_addr, waveform_state, fifo_select_pins, fifo_flags} = '0;
        seed = $urandom(41492);
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        idle(3);
        foreach (rst_adr[i]) begin
            fw.rd(rst_adr[i], d);
            chk("reset value", {8'h00, rst_val[i]}, {8'h00, d});
        end
        fw.wr(gcr_pkg::CPU_CS_OFS, 8'hFF);
        fw.rd(gcr_pkg::CPU_CS_OFS, d);
        chk("cpu_cs fixed bits", 16'h003E, {8'h00, d});
        for (int k = 0; k < 4; k++) begin
            cpu_clk_in <= 1'($urandom);
            fw.wr(gcr_pkg::CPU_CS_OFS, {3'b000, 2'(k), 1'(k), 2'b10});
            idle(4);
            if (k < 3) chk("cpu_clock_speed", 16'(k), {14'h0000, cpu_clock_speed});
            chk("cpu_clock_output", {15'h0000, cpu_clk_in ^ 1'(k)}, {15'h0000, cpu_clock_output});
            chk("cpu_clock_output_oe", 16'h0001, {15'h0000, cpu_clock_output_oe});
        end
        cpu_reset_req <= 1'b1;
        fw.wr(gcr_pkg::CPU_CS_OFS, 8'h00);
        idle(4);
        chk("cpu_clock_output_oe off", 16'h0000, {15'h0000, cpu_clock_output_oe});
        chk("cpu_hold_in_reset", 16'h0001, {15'h0000, cpu_hold_in_reset});
        fw.rd(gcr_pkg::CPU_CS_OFS, d);
        chk("cpu_cs hold bit", 16'h0001, {8'h00, d});
        cpu_reset_req <= 1'b0;
        repeat (12) begin
            v = 8'($urandom);
            {int_clk_30, int_clk_48, iface_clock_pin_in, waveform_state} <= 6'($urandom);
            fw.wr(gcr_pkg::IF_CFG_OFS, v);
            idle(4);
            fw.rd(gcr_pkg::IF_CFG_OFS, d);
            chk("if_cfg readback", {8'h00, v}, {8'h00, d});
            chk("iface_mode_select", {14'h0000, v[1:0]}, {14'h0000, iface_mode_select});
            chk("port_e_c_oe", {13'h0000, {3{v[2]}}}, {13'h0000, port_e_c_oe});
            if (v[2]) chk("port_e_c_out", {13'h0000, waveform_state}, {13'h0000, port_e_c_out});
            chk("iface_clock_pin_oe", {15'h0000, v[5]}, {15'h0000, iface_clock_pin_oe});
            ex[0] = ((v[7] | v[3]) ? (v[6] ? int_clk_48 : int_clk_30) : iface_clock_pin_in) ^ v[4];
            if (v[5]) chk("iface_clock_pin_out", {15'h0000, ex[0]}, {15'h0000, iface_clock_pin_out});
            if (v[7] == v[3]) chk("iface_clock_sel", {15'h0000, v[7]}, {15'h0000, iface_clock_sel});
        end
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            fifo_flags <= 12'($urandom);
            fifo_select_pins <= 2'($urandom);
            fw.wr(gcr_pkg::FLAG_AB_OFS, {~c, c});
            fw.wr(gcr_pkg::FLAG_CD_OFS, {c + 4'hA, c + 4'h5});
            idle(4);
            ex = {flag_exp(c + 4'hA, fifo_select_pins, fifo_flags), flag_exp(c + 4'h5, fifo_select_pins, fifo_flags),
                  flag_exp(~c, fifo_select_pins, fifo_flags), flag_exp(c, fifo_select_pins, fifo_flags)};
            chk("flag_pins", {12'h000, ex}, {12'h000, flag_pins});
        end
        fw.wr(gcr_pkg::IRQ_MASK_OFS, 8'h00);
        for (int k = 0; k < 4; k++) begin
            nak_seen = 1'b0;
            fw.restore(4'(1 << k));
            idle(2);
            chk("fifo_restore_strobe", 16'(1 << k), {12'h000, rst_seen});
            chk("nak during restore", 16'h0001, {15'h0000, nak_seen});
            chk("nak after restore", 16'h0000, {15'h0000, nak_all_transfers});
        end
        chk("irq masked", 16'h0000, {15'h0000, irq});
        fw.wr(gcr_pkg::IRQ_MASK_OFS, 8'h02);
        idle(2);
        chk("irq restore", 16'h0001, {15'h0000, irq});
        fw.wr(gcr_pkg::IRQ_STAT_OFS, 8'h02);
        idle(2);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        fw.wr(gcr_pkg::CPU_CS_OFS, 8'h20);
        {wr_pulses, rd_pulses} = '0;
        fw.wr(gcr_pkg::PORT_C_OFS, 8'h5A);
        fw.rd(gcr_pkg::PORT_C_OFS, d);
        fw.wr(gcr_pkg::CPU_CS_OFS, 8'h00);
        fw.wr(gcr_pkg::PORT_C_OFS, 8'hA5);
        fw.rd(gcr_pkg::PORT_C_OFS, d);
        idle(2);
        chk("port c write strobes", 16'h0001, 16'(wr_pulses));
        chk("port c read strobes", 16'h0001, 16'(rd_pulses));
        a = 16'($urandom);
        fw.wr(gcr_pkg::BRK_ADR_H_OFS, a[15:8]);
        fw.wr(gcr_pkg::BRK_ADR_L_OFS, a[7:0]);
        fw.wr(gcr_pkg::IRQ_MASK_OFS, 8'h01);
        fw.wr(gcr_pkg::BRK_CTL_OFS, 8'h02);
        fetch(a ^ 16'h0100);
        chk("break on miss", 16'h0000, {15'h0000, break_flag});
        fetch(a);
        fw.rd(gcr_pkg::BRK_CTL_OFS, d);
        chk("break latched", 16'h000A, {8'h00, d});
        chk("irq break", 16'h0001, {15'h0000, irq});
        fw.wr(gcr_pkg::BRK_CTL_OFS, 8'h0E);
        fw.wr(gcr_pkg::IRQ_STAT_OFS, 8'h01);
        idle(2);
        chk("break cleared", 16'h0000, {15'h0000, break_flag});
        chk("irq break cleared", 16'h0000, {15'h0000, irq});
        brk_cycles = 0;
        fetch(a);
        fw.wr(gcr_pkg::BRK_CTL_OFS, 8'h04);
        fetch(a);
        chk("break pulse cycles", 16'h0001, 16'(brk_cycles));
        repeat (8) begin
            a = gcr_pkg::WAVE_BASE + 16'($urandom_range(127));
            mem_model[int'(a)] = int'($urandom_range(255));
            fw.wr(a, 8'(mem_model[int'(a)]));
        end
        fw.wr(16'hE47F, 8'hC3);
        mem_model[32'hE47F] = 8'hC3;
        foreach (mem_model[k]) begin
            fw.rd(16'(k), d);
            chk("waveform memory", 16'(mem_model[k]), {8'h00, d});
        end
        stop_test();
    end
endmodule
